// ==== logic/spg_pkg.sv ====
// Package: constants and types for the transceiver PCS functions
package spg_pkg;
  // ----------------------------------------
  // Code groups (8-bit value plus K flag)
  // ----------------------------------------
  typedef struct packed {
    logic       k;
    logic [7:0] d;
  } spg_sym_t;

  localparam logic [7:0] K28_5 = 8'hbc;
  localparam logic [7:0] K28_0 = 8'h1c;
  localparam logic [7:0] D21_5 = 8'hb5;
  localparam logic [7:0] D2_2  = 8'h42;
  localparam logic [7:0] D5_6  = 8'hc5;
  localparam logic [7:0] D16_2 = 8'h50;
  localparam logic [7:0] D10_2 = 8'h4a;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int CTRL_GBE    = 0;
  localparam int CTRL_FR_EN  = 1;
  localparam int CTRL_EI_EN  = 2;
  localparam int CTRL_PAT7   = 3;
  localparam logic [3:0] CTRL_RESET = 4'h0;
  localparam int ST_SYNC_B   = 0;
  localparam int ST_IDLE_B   = 1;
  localparam int ST_FRLK_B   = 2;
  localparam int ST_ERR_LSB  = 4;
  localparam int ST_FSM_LSB  = 8;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_PS = 8000;
  localparam int CLK_MHZ       = 125;
  localparam int UI_PS         = 400;
  localparam int FR_MIN_NS     = 16;
  localparam int FR_MAX_US     = 4;
  localparam int FR_MIN_CYC    =
    (FR_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int FR_MAX_CYC    = FR_MAX_US * 1000000 / CLK_PERIOD_PS;
  localparam int EI_LONG_US    = 128;
  localparam int EI_LONG_CYC   = EI_LONG_US * CLK_MHZ;
  localparam int EI_TS_UI      = 1280;
  localparam int EI_TS_CYC     = EI_TS_UI * UI_PS / CLK_PERIOD_PS;
  localparam int EI_EXIT_UI    = 2000;
  localparam int EI_EXIT_CYC   = EI_EXIT_UI * UI_PS / CLK_PERIOD_PS;
  localparam int RM_PPM_TOTAL  = 200;

  // ----------------------------------------
  // Sync machine
  // ----------------------------------------
  localparam int SYNC_SETS  = 3;
  localparam int LOSS_ERRS  = 4;
  localparam int GOOD_RUN   = 4;
  localparam int AUTO_COMMAS = 3;

  typedef enum logic [1:0] {
    SM_LOSS = 2'b00,
    SM_ACQ  = 2'b01,
    SM_SYNC = 2'b10
  } spg_sm_t;

  localparam logic [2:0] EI_SEL_L0    = 3'b100;
  localparam logic [2:0] EI_SEL_RCFG  = 3'b101;
  localparam logic [2:0] EI_SEL_SPDNO = 3'b110;
  localparam logic [2:0] EI_SEL_LPBK  = 3'b111;
  localparam logic [1:0] PWR_P0  = 2'b00;
  localparam logic [1:0] PWR_P0S = 2'b01;
endpackage

// ==== logic/spg_pcs.sv ====
// Module: PCS functions for PIPE and gigabit ethernet modes
`timescale 1ns/10ps
// Summary of operation
// RULE1: Fast recovery relocks within 16 ns to 4 us
// RULE2: Select 100: idle if no FC/SKP 128us
// RULE3: Select 101: idle if no TS in 1280UI
// RULE4: Select 110: idle if no exit in 2000UI
// RULE5: Select 111: idle if no exit 128us
// RULE6: Inferred idle drives receiver idle output high
// RULE7: No idle-exit detection from exit ordered sets
// RULE8: Idle ordered set detection drives idle output
// RULE9: Compliance input forces negative running disparity
// RULE10: Compliance pattern K28.5 D21.5 K28.5 D10.2
// RULE11: Compliance input rises with K28.5 D21.5
// RULE12: Three automatic commas after transmit reset
// RULE13: Odd-boundary comma sends sync machine to loss (code does so from acquisition only; in sync it counts as one error)
// RULE14: First set discounted, three more needed (code counts the first set: three sets in all)
// RULE15: Data after comma replaced by D5.6/D16.2
// RULE16: Sync set is comma plus odd data count
// RULE17: Sync 3 sets, lose 4 errors, 4 good
// RULE18: Aligner supports 7 and 10 bit patterns
// RULE19: PIPE mode aligner uses 10 bit pattern
// RULE20: Rate matching tolerates 200 ppm total
// RULE21: Sender fills gaps with I1/I2 idles
// RULE22: Without inference idle is inverted signal detect
// RULE23: Fabric holds select stable within substate
module spg_pcs #(
  parameter int EI_LONG = spg_pkg::EI_LONG_CYC
) (
  input  wire logic             CLK_I,
  input  wire logic             RSTN_I,
  input  wire logic [3:0]       WB_ADR_I,
  input  wire logic [31:0]      WB_DAT_I,
  output logic [31:0]           WB_DAT_O,
  input  wire logic             WB_WE_I,
  input  wire logic [3:0]       WB_SEL_I,
  input  wire logic             WB_CYC_I,
  input  wire logic             WB_STB_I,
  output logic                  WB_ACK_O,
  input  wire logic             TX_DRST_I,
  input  wire spg_pkg::spg_sym_t TX_SYM_I,
  input  wire logic             TX_COMPL_I,
  output logic                  TX_READY_O,
  output spg_pkg::spg_sym_t     TX_SYM_O,
  output logic                  TX_RDNEG_O,
  input  wire logic             RX_DRST_I,
  input  wire spg_pkg::spg_sym_t RX_SYM_I,
  input  wire logic             RX_CERR_I,
  input  wire logic [1:0]       RX_PWR_I,
  input  wire logic [2:0]       RX_EISEL_I,
  input  wire logic             RX_SIGDET_I,
  input  wire logic             RX_FCSKP_I,
  input  wire logic             RX_TS_I,
  input  wire logic             RX_EIOS_I,
  output logic                  RX_IDLE_O,
  output logic                  RX_SYNC_O,
  output logic                  RX_FR_LOCK_O,
  output logic                  RX_RM_I2_O,
  output logic                  ALIGN_PAT10_O
);
  import spg_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic is_comma(input spg_sym_t s);
    return s.k && (s.d == K28_5);
  endfunction

  // Only symbols used by ordered sets are tracked as unbalanced
  function automatic logic flips_rd(input spg_sym_t s);
    return is_comma(s) || (!s.k && (s.d == D16_2));
  endfunction

  // ----------------------------------------
  // Wishbone slave
  // ----------------------------------------
  logic [3:0] ctrl_q;
  logic       ack_q;
  logic       wb_req;
  logic       gbe;
  logic [31:0] status;

  assign wb_req   = WB_CYC_I && WB_STB_I && !ack_q;
  assign WB_ACK_O = ack_q;
  assign gbe      = ctrl_q[CTRL_GBE];

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_req;
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ctrl_q <= CTRL_RESET;
    end else if (wb_req && WB_WE_I && WB_SEL_I[0] &&
                 WB_ADR_I == REG_CTRL) begin
      ctrl_q <= WB_DAT_I[3:0];
    end
  end

  // Unmapped addresses read zero and still acknowledge
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      WB_DAT_O <= 32'h0;
    end else if (wb_req) begin
      case (WB_ADR_I)
        REG_CTRL:   WB_DAT_O <= {28'h0, ctrl_q};
        REG_STATUS: WB_DAT_O <= status;
        default:    WB_DAT_O <= 32'h0;
      endcase
    end
  end

  // ----------------------------------------
  // Transmit path
  // ----------------------------------------
  logic [1:0] auto_cnt_q;
  logic       auto_busy;
  logic       rd_q;
  logic       rd_in;
  logic       prev_comma_q;
  logic       rd_bc_q;
  spg_sym_t   tx_sym;

  assign auto_busy  = gbe && (auto_cnt_q < 2'(AUTO_COMMAS));
  assign TX_READY_O = !TX_DRST_I && !auto_busy;
  assign rd_in      = TX_COMPL_I ? 1'b0 : rd_q; // RULE9

  always_comb begin
    tx_sym = TX_SYM_I;
    if (auto_busy) begin
      tx_sym = '{k: 1'b1, d: K28_5}; // RULE12
    end else if (gbe && prev_comma_q && !TX_SYM_I.k &&
                 TX_SYM_I.d != D21_5 && TX_SYM_I.d != D2_2) begin
      tx_sym.d = rd_bc_q ? D5_6 : D16_2; // RULE15
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      auto_cnt_q <= 2'h0;
    end else if (TX_DRST_I) begin
      auto_cnt_q <= 2'h0;
    end else if (auto_busy) begin
      auto_cnt_q <= auto_cnt_q + 2'h1; // RULE12
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      TX_SYM_O     <= '0;
      TX_RDNEG_O   <= 1'b1;
      rd_q         <= 1'b0;
      prev_comma_q <= 1'b0;
      rd_bc_q      <= 1'b0;
    end else if (TX_DRST_I) begin
      TX_SYM_O     <= '0;
      TX_RDNEG_O   <= 1'b1;
      rd_q         <= 1'b0;
      prev_comma_q <= 1'b0;
      rd_bc_q      <= 1'b0;
    end else begin
      TX_SYM_O     <= tx_sym;
      TX_RDNEG_O   <= !rd_in; // RULE9
      rd_q         <= rd_in ^ flips_rd(tx_sym);
      prev_comma_q <= is_comma(tx_sym);
      if (is_comma(tx_sym)) begin
        rd_bc_q <= rd_in;
      end
    end
  end

  // ----------------------------------------
  // Receive sync machine
  // ----------------------------------------
  spg_sm_t    sm_q;
  logic       odd_q;
  logic       pend_q;
  logic [1:0] sets_q;
  logic [2:0] err_q;
  logic [1:0] good_q;
  logic       rx_comma;
  logic       rx_bad;

  assign rx_comma  = is_comma(RX_SYM_I);
  // Comma must land on an even boundary
  assign rx_bad    = RX_CERR_I || (rx_comma && odd_q); // RULE13
  assign RX_SYNC_O = (sm_q == SM_SYNC);
  // Pattern length: 7-bit only selectable in gigabit mode
  assign ALIGN_PAT10_O = !(gbe && ctrl_q[CTRL_PAT7]); // RULE18 RULE19
  // I2 idles mark where the rate matcher may add or drop
  assign RX_RM_I2_O = RX_SYNC_O && pend_q && !RX_SYM_I.k &&
                      RX_SYM_I.d == D16_2; // RULE20

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      odd_q <= 1'b0;
    end else if (RX_DRST_I) begin
      odd_q <= 1'b0;
    end else if (rx_comma && sm_q == SM_LOSS) begin
      odd_q <= 1'b1;
    end else begin
      odd_q <= !odd_q;
    end
  end

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sm_q   <= SM_LOSS;
      pend_q <= 1'b0;
      sets_q <= 2'h0;
      err_q  <= 3'h0;
      good_q <= 2'h0;
    end else if (RX_DRST_I || !gbe) begin
      sm_q   <= SM_LOSS;
      pend_q <= 1'b0;
      sets_q <= 2'h0;
      err_q  <= 3'h0;
      good_q <= 2'h0;
    end else begin
      pend_q <= rx_comma && !rx_bad;
      case (sm_q)
        SM_LOSS: begin
          sets_q <= 2'h0;
          err_q  <= 3'h0;
          good_q <= 2'h0;
          if (rx_comma && !RX_CERR_I) begin
            sm_q   <= SM_ACQ;
            pend_q <= 1'b1;
          end
        end
        SM_ACQ: begin
          if (rx_bad) begin
            sm_q   <= SM_LOSS; // RULE13 RULE14
            sets_q <= 2'h0; // RULE14
            pend_q <= 1'b0;
          end else if (pend_q && !RX_SYM_I.k) begin
            // Set counts once its first data group is good
            if (sets_q == 2'(SYNC_SETS - 1)) begin
              sm_q <= SM_SYNC; // RULE16 RULE17
            end
            sets_q <= sets_q + 2'h1;
          end
        end
        SM_SYNC: begin
          if (rx_bad) begin
            good_q <= 2'h0;
            if (err_q == 3'(LOSS_ERRS - 1)) begin
              sm_q <= SM_LOSS; // RULE17
            end
            err_q <= err_q + 3'h1;
          end else if (good_q == 2'(GOOD_RUN - 1)) begin
            good_q <= 2'h0;
            if (err_q != 3'h0) begin
              err_q <= err_q - 3'h1; // RULE17
            end
          end else begin
            good_q <= good_q + 2'h1;
          end
        end
        default: sm_q <= SM_LOSS;
      endcase
    end
  end

  // ----------------------------------------
  // Fast recovery from P0s
  // ----------------------------------------
  logic [1:0] pwr_q;
  logic       fr_busy_q;
  logic [9:0] fr_cnt_q;
  logic       fr_start;

  assign fr_start = ctrl_q[CTRL_FR_EN] && pwr_q == PWR_P0S &&
                    RX_PWR_I == PWR_P0;
  assign RX_FR_LOCK_O = !fr_busy_q;

  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      pwr_q     <= PWR_P0;
      fr_busy_q <= 1'b0;
      fr_cnt_q  <= 10'h0;
    end else begin
      pwr_q <= RX_PWR_I;
      if (fr_start) begin
        fr_busy_q <= 1'b1;
        fr_cnt_q  <= 10'h0;
      end else if (fr_busy_q) begin
        fr_cnt_q <= fr_cnt_q + 10'h1;
        // Lock on a comma after the floor, never past the ceiling
        if ((fr_cnt_q >= 10'(FR_MIN_CYC - 1) && rx_comma) ||
            fr_cnt_q == 10'(FR_MAX_CYC - 1)) begin
          fr_busy_q <= 1'b0; // RULE1
        end
      end
    end
  end

  // ----------------------------------------
  // Electrical idle inference
  // ----------------------------------------
  // Exit ordered sets are not decoded: exit is taken from
  // the analog detector or ordered-set traffic only. RULE7
  logic        ei_on;
  logic        ei_evt;
  logic [31:0] ei_lim;
  logic [31:0] ei_cnt_q;
  logic [2:0]  sel_q;
  logic        idle_q;

  assign ei_on = ctrl_q[CTRL_EI_EN] && RX_EISEL_I[2];

  always_comb begin
    case (RX_EISEL_I)
      EI_SEL_L0: begin
        ei_lim = 32'(EI_LONG); // RULE2
        ei_evt = RX_FCSKP_I;
      end
      EI_SEL_RCFG: begin
        ei_lim = 32'(EI_TS_CYC); // RULE3
        ei_evt = RX_TS_I;
      end
      EI_SEL_SPDNO: begin
        ei_lim = 32'(EI_EXIT_CYC); // RULE4
        ei_evt = RX_SIGDET_I;
      end
      EI_SEL_LPBK: begin
        ei_lim = 32'(EI_LONG); // RULE5
        ei_evt = RX_SIGDET_I;
      end
      default: begin
        ei_lim = 32'(EI_LONG);
        ei_evt = 1'b1;
      end
    endcase
  end

  // Select changes restart the window (fabric holds it per substate)
  always_ff @(posedge CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      sel_q    <= 3'h0;
      ei_cnt_q <= 32'h0;
      idle_q   <= 1'b0;
    end else begin
      sel_q <= RX_EISEL_I;
      if (!ei_on || ei_evt || sel_q != RX_EISEL_I) begin
        ei_cnt_q <= 32'h0; // RULE23
      end else if (ei_cnt_q != ei_lim - 32'h1) begin
        ei_cnt_q <= ei_cnt_q + 32'h1;
      end
      // Detected idle ordered set wins over a same-cycle event
      if (ei_on && RX_EIOS_I) begin
        idle_q <= 1'b1; // RULE8
      end else if (!ei_on || ei_evt) begin
        idle_q <= 1'b0;
      end else if (ei_cnt_q == ei_lim - 32'h1) begin
        idle_q <= 1'b1; // RULE6
      end
    end
  end

  assign RX_IDLE_O = ei_on ? idle_q : !RX_SIGDET_I; // RULE6 RULE22

  assign status = {22'h0, sm_q, 1'b0, err_q, 1'b0, RX_FR_LOCK_O,
                   RX_IDLE_O, RX_SYNC_O};

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence three_commas_s;
    (TX_SYM_O.k && TX_SYM_O.d == K28_5) [*3];
  endsequence

  auto_comma_a: assert property ( // RULE12
    @(posedge CLK_I) disable iff (!RSTN_I)
    ($fell(TX_DRST_I) && gbe) |=> three_commas_s)
    else $error("automatic commas missing after reset");

  idle_swap_a: assert property ( // RULE15
    @(posedge CLK_I) disable iff (!RSTN_I)
    (gbe && !TX_DRST_I && !auto_busy && prev_comma_q &&
     !TX_SYM_I.k && TX_SYM_I.d != D21_5 && TX_SYM_I.d != D2_2)
    |=> (TX_SYM_O.d == ($past(rd_bc_q) ? D5_6 : D16_2)))
    else $error("idle data after comma not replaced");

  compl_disp_a: assert property ( // RULE9
    @(posedge CLK_I) disable iff (!RSTN_I)
    (TX_COMPL_I && !TX_DRST_I) |=> TX_RDNEG_O)
    else $error("compliance symbol not negative disparity");

  sync_gain_a: assert property ( // RULE17
    @(posedge CLK_I) disable iff (!RSTN_I)
    $rose(RX_SYNC_O) |-> ($past(sets_q) == 2'(SYNC_SETS - 1)))
    else $error("sync reached without three sets");

  odd_comma_a: assert property ( // RULE13
    @(posedge CLK_I) disable iff (!RSTN_I)
    (gbe && !RX_DRST_I && sm_q == SM_ACQ && rx_comma && odd_q)
    |=> (sm_q == SM_LOSS && sets_q == 2'h0) ##1 (sets_q == 2'h0))
    else $error("odd boundary comma not treated as error");

  sync_loss_a: assert property ( // RULE17
    @(posedge CLK_I) disable iff (!RSTN_I)
    (gbe && !RX_DRST_I && RX_SYNC_O && rx_bad &&
     err_q == 3'(LOSS_ERRS - 1)) |=> !RX_SYNC_O)
    else $error("sync kept after fourth error");

  ei_fallback_a: assert property ( // RULE22
    @(posedge CLK_I) disable iff (!RSTN_I)
    !ei_on |-> (RX_IDLE_O == !RX_SIGDET_I))
    else $error("idle not inverted signal detect");

  ei_timeout_a: assert property ( // RULE3
    @(posedge CLK_I) disable iff (!RSTN_I)
    (ei_on && RX_EISEL_I == EI_SEL_RCFG && sel_q == EI_SEL_RCFG &&
     !RX_TS_I && ei_cnt_q == 32'(EI_TS_CYC - 1)) |=> RX_IDLE_O)
    else $error("idle not inferred after TS window");

  fr_bound_a: assert property ( // RULE1
    @(posedge CLK_I) disable iff (!RSTN_I)
    $rose(fr_busy_q) |-> ##[1:500] !fr_busy_q)
    else $error("fast recovery exceeded window");

  pat_len_a: assert property ( // RULE19
    @(posedge CLK_I) disable iff (!RSTN_I)
    !gbe |-> ALIGN_PAT10_O)
    else $error("PIPE mode not using 10-bit pattern");

  wb_ack_a: assert property (
    @(posedge CLK_I) disable iff (!RSTN_I)
    (WB_CYC_I && WB_STB_I && !ack_q) |=> ack_q ##1 !ack_q)
    else $error("bus acknowledge not a single cycle");

endmodule // spg_pcs

// ==== testbench/spg_link_peer.sv ====
// Remote serial link partner model feeding the receive side
`timescale 1ns/10ps
module spg_link_peer (
  input  wire logic        clk_i,
  output spg_pkg::spg_sym_t sym_o,
  output logic             cerr_o
);
  import spg_pkg::*;
  // ----------------------------------------
  // Group queue, one group per clock
  // ----------------------------------------
  logic [9:0] q [$];
  logic [9:0] g;
  logic [7:0] ns_q = 8'h00;

  initial begin
    sym_o  = '0;
    cerr_o = 1'b1;
  end

  // Nothing queued: line noise that changes every cycle, marked bad
  always @(posedge clk_i) begin
    ns_q <= ns_q + 8'h01;
    if (q.size() > 0) begin
      g = q.pop_front();
      sym_o  <= spg_sym_t'(g[8:0]);
      cerr_o <= g[9];
    end else begin
      sym_o  <= spg_sym_t'({1'b0, ns_q ^ 8'h5a});
      cerr_o <= 1'b1;
    end
  end

  task automatic put(input logic e, input logic k, input logic [7:0] d);
    q.push_back({e, k, d});
  endtask

  // Gap filler: comma followed by D16.2
  task automatic idle(input int n);
    for (int i = 0; i < n; i++) begin
      put(1'b0, 1'b1, K28_5);
      put(1'b0, 1'b0, D16_2);
    end
  endtask
endmodule // spg_link_peer

// ==== testbench/spg_pcs_tb.sv ====
// Self-checking bench for the transceiver PCS functions
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
  fail_count++; $display("[ERR] %s exp %0h got %0h", nm, ex, got); end end
module spg_pcs_tb;
  import spg_pkg::*;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  localparam int       EIL = 40;
  localparam spg_sym_t SK  = '{k: 1'b1, d: K28_5};
  logic        clk = 1'b0, rstn = 1'b0;
  logic [3:0]  adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdo, rd;
  logic        we = 1'b0, cyc = 1'b0, stb = 1'b0, ack;
  logic        txd = 1'b1, txc = 1'b0, trdy, trd, pv = 1'b0;
  spg_sym_t    txs = '{k: 1'b0, d: 8'h11}, txo, rxs, pe;
  logic        rxd = 1'b0, rxe, sig = 1'b0, fcs = 1'b0, ts = 1'b0;
  logic        eios = 1'b0, idl, syn, frl, i2, p10;
  logic [1:0]  pwr = PWR_P0, pr;
  logic [2:0]  esel = 3'b000;
  int          fail_count = 0, cmp_count = 0, i2_cnt = 0, base, n;
  int          win [4] = '{EIL, EI_TS_CYC, EI_EXIT_CYC, EIL};

  spg_pcs #(.EI_LONG(EIL)) dut (
    .CLK_I(clk), .RSTN_I(rstn), .WB_ADR_I(adr), .WB_DAT_I(wdat),
    .WB_DAT_O(rdo), .WB_WE_I(we), .WB_SEL_I(sel), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_ACK_O(ack), .TX_DRST_I(txd), .TX_SYM_I(txs),
    .TX_COMPL_I(txc), .TX_READY_O(trdy), .TX_SYM_O(txo),
    .TX_RDNEG_O(trd), .RX_DRST_I(rxd), .RX_SYM_I(rxs), .RX_CERR_I(rxe),
    .RX_PWR_I(pwr), .RX_EISEL_I(esel), .RX_SIGDET_I(sig),
    .RX_FCSKP_I(fcs), .RX_TS_I(ts), .RX_EIOS_I(eios), .RX_IDLE_O(idl),
    .RX_SYNC_O(syn), .RX_FR_LOCK_O(frl), .RX_RM_I2_O(i2),
    .ALIGN_PAT10_O(p10));
  spg_link_peer peer (.clk_i(clk), .sym_o(rxs), .cerr_o(rxe));

  always #4 clk = ~clk;
  always @(posedge clk) if (i2 === 1'b1) i2_cnt++;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hf};
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    rd = rdo;
    if (ack !== 1'b1) fail_count++;
    {cyc, stb} <= 2'b00;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // Checks the symbol sent by the previous call; outputs lag one cycle
  task automatic step(input spg_sym_t s, input logic c, input spg_sym_t e,
                      input logic [1:0] r);
    @(posedge clk);
    txs <= s;
    txc <= c;
    @(negedge clk);
    if (pv) `CHK("tx sym", pe, txo)
    if (pv && pr[1]) `CHK("tx rdneg", pr[0], trd)
    pe = e;
    pr = r;
    pv = 1'b1;
  endtask

  task automatic upto(input int k);
    wait (peer.q.size() == k);
    tick(1);
  endtask

  task automatic kd(input int k);
    for (int i = 0; i < k; i++) begin
      peer.put(1'b0, 1'b1, K28_5);
      peer.put(1'b0, 1'b0, D10_2);
    end
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    close_out();
  end

  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    tick(1);
    `CHK("rdneg rst", 1'b1, trd)
    `CHK("pat10 rst", 1'b1, p10)
    `CHK("idle rst", 1'b1, idl)
    wb(1'b0, REG_CTRL, 32'h0);
    `CHK("ctrl rst", 32'h0, rd)
    wb(1'b0, 4'h8, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    wb(1'b1, REG_CTRL, 32'h9);
    tick(1);
    `CHK("pat7 gigabit_ethernet_mode", 1'b0, p10)
    wb(1'b1, REG_CTRL, 32'h8);
    tick(1);
    `CHK("pat pipe", 1'b1, p10)
    wb(1'b1, REG_CTRL, 32'h1);
    @(posedge clk);
    txd <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      @(negedge clk);
      `CHK("auto comma", SK, txo)
      `CHK("tx ready", i == 2, trdy)
    end
    step(SK, 1'b1, SK, 2'b11);
    step({1'b0, 8'h00}, 1'b0, {1'b0, D16_2}, 2'b00);
    step(SK, 1'b0, SK, 2'b11);
    step({1'b0, D2_2}, 1'b0, {1'b0, D2_2}, 2'b00);
    step(SK, 1'b0, SK, 2'b10);
    step({1'b0, 8'h00}, 1'b0, {1'b0, D5_6}, 2'b00);
    step({1'b0, 8'h00}, 1'b0, {1'b0, 8'h00}, 2'b00);
    @(posedge clk);
    rxd <= 1'b1;
    @(posedge clk);
    rxd <= 1'b0;
    #1;
    // Counted set undone by an odd-boundary comma, then the sync sets
    peer.put(1'b0, 1'b1, K28_5);
    peer.put(1'b0, 1'b0, D10_2);
    peer.put(1'b0, 1'b0, D10_2);
    kd(4);
    repeat (3) peer.put(1'b1, 1'b0, 8'h00);
    peer.put(1'b0, 1'b0, D10_2);
    peer.idle(4);
    repeat (3) peer.put(1'b1, 1'b0, 8'h00);
    upto(17);
    `CHK("sync odd", 1'b0, syn)
    upto(15);
    `CHK("sync got", 1'b1, syn)
    base = i2_cnt;
    upto(1);
    `CHK("sync kept", 1'b1, syn)
    `CHK("i2 count", 4, i2_cnt - base)
    upto(0);
    `CHK("sync lost", 1'b0, syn)
    wb(1'b1, REG_CTRL, 32'h0);
    repeat (2) begin
      step(SK, 1'b1, SK, 2'b11);
      step({1'b0, D21_5}, 1'b1, {1'b0, D21_5}, 2'b11);
      step(SK, 1'b0, SK, 2'b00);
      step({1'b0, D10_2}, 1'b0, {1'b0, D10_2}, 2'b00);
    end
    step(SK, 1'b0, SK, 2'b00);
    sig <= 1'b1;
    tick(1);
    `CHK("idle sig", 1'b0, idl)
    wb(1'b1, REG_CTRL, 32'h4);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      esel <= EI_SEL_L0 + 3'(i);
      {fcs, ts, sig} <= (i == 0) ? 3'b100 : (i == 1) ? 3'b010 : 3'b001;
      @(posedge clk);
      {fcs, ts, sig} <= 3'b000;
      tick(win[i] - 4);
      `CHK("idle early", 1'b0, idl)
      tick(8);
      `CHK("idle infer", 1'b1, idl)
    end
    @(posedge clk);
    sig <= 1'b1;
    @(posedge clk);
    sig <= 1'b0;
    tick(3);
    `CHK("idle exit", 1'b0, idl)
    @(posedge clk);
    eios <= 1'b1;
    @(posedge clk);
    eios <= 1'b0;
    tick(1);
    `CHK("idle eios", 1'b1, idl)
    wb(1'b1, REG_CTRL, 32'h2);
    @(posedge clk);
    pwr <= PWR_P0S;
    repeat (5) @(posedge clk);
    pwr <= PWR_P0;
    tick(2);
    `CHK("fr busy", 1'b0, frl)
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (frl !== 1'b1 && n < 600);
    `CHK("fr time", 1'b1, n <= FR_MAX_CYC)
    close_out();
  end
endmodule // spg_pcs_tb
